// File: src/wave_timer_cfg.svh
`ifndef WAVE_TIMER_CFG_SVH
`define WAVE_TIMER_CFG_SVH

// register indices, byte address is four times the index
`define REG_CTRL_A 6'h00
`define REG_CTRL_B 6'h01
`define REG_CTRL_C 6'h02
`define REG_CTRL_D 6'h03
`define REG_CTRL_E_CLR 6'h04
`define REG_CTRL_E_SET 6'h05
`define REG_CTRL_F_CLR 6'h06
`define REG_CTRL_F_SET 6'h07
`define REG_FLAGS 6'h08
`define REG_COUNT 6'h09
`define REG_CYCLE 6'h0a
`define REG_CYCLE_SHD 6'h0b
`define REG_THR0 6'h0c
`define REG_SHD0 6'h0f
`define REG_LAST 6'h11

// field positions
`define CTRL_A_ENABLE 0
`define CTRL_A_PRESC_LSB 1
`define CTRL_B_EN_LSB 4
`define CTRL_D_SPLIT 0
`define CTRL_E_DIR 0
`define CTRL_E_HOLD 1
`define CTRL_E_CMD_LSB 2
`define FLAG_LOW_UNF 0
`define FLAG_HIGH_UNF 1
`define FLAG_CMP_LSB 4

// wave shape codes
`define SHAPE_NORMAL 3'h0
`define SHAPE_FREQ 3'h1
`define SHAPE_ONE_RAMP 3'h3
`define SHAPE_DUAL_TOP 3'h5
`define SHAPE_DUAL_BOTH 3'h6
`define SHAPE_DUAL_BOTTOM 3'h7

// command codes
`define CMD_NONE 2'h0
`define CMD_UPDATE 2'h1
`define CMD_RESTART 2'h2
`define CMD_RESET 2'h3

// reset values
`define RST_CYCLE 16'hffff
`define RST_ZERO16 16'h0000

`endif

// File: src/wave_timer_pkg.sv
package wave_timer_pkg;
	typedef logic [15:0] word16_t;
	typedef logic [2:0] shape_t;
	typedef logic [1:0] cmd_t;
	typedef logic [5:0] reg_index_t;
endpackage

// File: src/prescale_divider.sv
`timescale 1ns/100ps
// divides clk_sys into a one-cycle tick: 1,2,4,8,16,64,256,1024
module prescale_divider
	import wave_timer_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic run,
	input wire logic [2:0] select,
	output logic tick
);
	logic [9:0] div_reg;
	logic [9:0] mask;

	// mask of low bits that must all be one for a tick
	always_comb
	begin
		unique case (select)
			3'h0: mask = 10'h000;
			3'h1: mask = 10'h001;
			3'h2: mask = 10'h003;
			3'h3: mask = 10'h007;
			3'h4: mask = 10'h00f;
			3'h5: mask = 10'h03f;
			3'h6: mask = 10'h0ff;
			3'h7: mask = 10'h3ff;
		endcase
	end

	// divider is held at zero while stopped so the first tick phase is known
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			div_reg <= 10'h000;
		else if (!run)
			div_reg <= 10'h000;
		else
			div_reg <= div_reg + 10'h001;
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			tick <= 1'b0;
		else
			tick <= run && ((div_reg & mask) == mask);
	end
endmodule // prescale_divider

// File: src/compare_store.sv
`timescale 1ns/100ps
`include "wave_timer_cfg.svh"
// active value, shadow and shadow-valid flag of one 16-bit compare register
module compare_store
	import wave_timer_pkg::*;
#(
	parameter word16_t RESET_VALUE = `RST_ZERO16
)
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic soft_clear,
	input wire logic active_wr,
	input wire logic shadow_wr,
	input wire logic [1:0] wr_strb,
	input wire logic [15:0] wr_data,
	input wire logic update_load,
	input wire logic valid_set,
	input wire logic valid_clr,
	output word16_t active,
	output word16_t shadow,
	output logic shadow_valid
);
	function automatic word16_t merge(word16_t old, logic [15:0] d, logic [1:0] s);
		merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
	endfunction

	// a direct write wins over a copy from the shadow
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			active <= RESET_VALUE;
		else if (soft_clear)
			active <= RESET_VALUE;
		else if (active_wr)
			active <= merge(active, wr_data, wr_strb);
		else if (update_load && shadow_valid)
			active <= shadow;
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			shadow <= RESET_VALUE;
		else if (soft_clear)
			shadow <= RESET_VALUE;
		else if (shadow_wr)
			shadow <= merge(shadow, wr_data, wr_strb);
	end

	// a set in the same cycle as the copy keeps the flag up
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			shadow_valid <= 1'b0;
		else if (soft_clear)
			shadow_valid <= 1'b0;
		else if (shadow_wr || valid_set)
			shadow_valid <= 1'b1;
		else if (update_load || valid_clr)
			shadow_valid <= 1'b0;
	end
endmodule // compare_store

// File: src/wave_timer.sv
// Our own choices: register access over APB and the address map.
`timescale 1ns/100ps
`include "wave_timer_cfg.svh"
// Functional notes
// - without shadow use a period write takes effect immediately
// - counting up, a period below the count wraps through all ones first
// - period shadow writable anytime outside split mode, copied to active only on update
// - count equal to threshold sets that channel's flag one tick later
// - each threshold has a shadow copied at top or bottom or by an update command
// - lower pin driven by waveform only with drive enable set and a shape selected or split mode on
// - frequency mode: threshold zero sets top, outputs toggle on each match
// - frequency mode, threshold zero and no prescale toggles every clock
// - single ramp: count bottom to period, set at bottom, clear on match
// - single ramp: threshold zero gives low, above period gives high
// - single ramp period two to all ones minus one; freq clk/(N*(per+1))
// - dual ramp: up then down, clear on up match, set on down match
// - dual ramp: threshold zero gives low, threshold equal period gives high
// - dual ramp period three to all ones; freq clk/(2*N*per)
// - commands written to control e set; update ignores hold bit
// - restart clears count, direction and all outputs at once
// - reset command restores every register, only while disabled
// - split mode: two independent 8-bit down counters, three channels each
// - split mode: no event counting, shadows and valid flags unused
// - split: upper half underflow flag, no upper compare flags
// - split mode registers accept single byte accesses
// - update at top or bottom per shape copies valid shadows unless held
// - shadow write sets its valid flag, the copy clears it
module wave_timer
	import wave_timer_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [5:0] port_out_value,
	output logic [5:0] wave_out_pin,
	output logic [5:0] wave_override
);
	logic enable_reg;
	logic [2:0] prescale_select;
	shape_t wave_shape_select;
	logic [2:0] channel_drive_enable;
	logic [2:0] ctrl_c_reg;
	logic split_reg;
	logic dir_reg;
	logic hold_reload_bit;
	logic [6:0] flags_reg;
	word16_t count_value;
	logic [2:0] wave_lo_reg;
	logic [2:0] wave_hi_reg;
	logic [31:0] rd_data;
	logic mapped;
	logic wr_fire;
	logic tick;
	reg_index_t idx;
	logic [1:0] strb16;
	cmd_t cmd;
	logic cmd_fire;
	logic soft_clear;
	logic restart;
	word16_t cycle_active;
	word16_t cycle_shadow;
	logic cycle_valid;
	word16_t thr [3];
	word16_t thr_shadow [3];
	logic [2:0] thr_valid;
	word16_t top;
	logic run;
	logic dual;
	logic at_top;
	logic at_bottom;
	logic top_evt;
	logic bottom_evt;
	logic update_cond;
	logic update_load;
	logic going_down;
	logic lo_bottom;
	logic hi_bottom;
	logic [2:0] match;
	logic [2:0] match_hi;
	logic [6:0] flag_set;

	assign idx = paddr[7:2];
	assign wr_fire = psel && penable && pready && pwrite;
	assign strb16 = pstrb[1:0];
	assign cmd = pwdata[`CTRL_E_CMD_LSB +: 2];
	assign cmd_fire = wr_fire && (idx == `REG_CTRL_E_SET) && pstrb[0];
	// reset command is refused while the timer runs
	assign soft_clear = cmd_fire && (cmd == `CMD_RESET) && !enable_reg;
	assign restart = cmd_fire && (cmd == `CMD_RESTART);
	assign run = enable_reg;
	assign dual = wave_shape_select[2];

	// prescaled tick source
	prescale_divider u_presc (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.run(run),
		.select(prescale_select),
		.tick(tick)
	);

	// frequency mode takes its top from threshold zero
	assign top = (wave_shape_select == `SHAPE_FREQ) ? thr[0] : cycle_active;
	// equality only, so a lowered period lets the count run on to wrap
	assign at_top = (count_value == top);
	assign at_bottom = (count_value == `RST_ZERO16);
	assign top_evt = tick && run && !split_reg && !dir_reg && at_top;
	assign bottom_evt = tick && run && !split_reg && dir_reg && at_bottom;
	assign lo_bottom = (count_value[7:0] == 8'h00);
	assign hi_bottom = (count_value[15:8] == 8'h00);
	// direction after this tick, used by dual ramp matches
	assign going_down = dir_reg ? !at_bottom : at_top;

	// update point depends on the wave shape
	always_comb
	begin
		unique case (wave_shape_select)
			`SHAPE_DUAL_TOP: update_cond = top_evt;
			`SHAPE_DUAL_BOTTOM: update_cond = bottom_evt;
			default: update_cond = top_evt || bottom_evt;
		endcase
	end

	// shadows never copy in split mode
	assign update_load = !split_reg && ((update_cond && !hold_reload_bit)
		|| (cmd_fire && (cmd == `CMD_UPDATE)));

	// period store; direct writes are immediate, shadow waits for update
	compare_store #(
		.RESET_VALUE(`RST_CYCLE)
	) u_cycle (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.soft_clear(soft_clear),
		.active_wr(wr_fire && (idx == `REG_CYCLE)),
		.shadow_wr(wr_fire && (idx == `REG_CYCLE_SHD) && !split_reg),
		.wr_strb(strb16),
		.wr_data(pwdata[15:0]),
		.update_load(update_load),
		.valid_set(wr_fire && (idx == `REG_CTRL_F_SET) && pwdata[0]),
		.valid_clr(wr_fire && (idx == `REG_CTRL_F_CLR) && pwdata[0]),
		.active(cycle_active),
		.shadow(cycle_shadow),
		.shadow_valid(cycle_valid)
	);

	// per channel threshold, compare and waveform
	genvar n;
	generate
		for (n = 0; n < 3; n++)
		begin : g_chan
			compare_store #(
				.RESET_VALUE(`RST_ZERO16)
			) u_thr (
				.clk_sys(clk_sys),
				.rst_n(rst_n),
				.soft_clear(soft_clear),
				.active_wr(wr_fire && (idx == `REG_THR0 + 6'(n))),
				.shadow_wr(wr_fire && (idx == `REG_SHD0 + 6'(n)) && !split_reg),
				.wr_strb(strb16),
				.wr_data(pwdata[15:0]),
				.update_load(update_load),
				.valid_set(wr_fire && (idx == `REG_CTRL_F_SET) && pwdata[n + 1]),
				.valid_clr(wr_fire && (idx == `REG_CTRL_F_CLR) && pwdata[n + 1]),
				.active(thr[n]),
				.shadow(thr_shadow[n]),
				.shadow_valid(thr_valid[n])
			);

			assign match[n] = split_reg ? (count_value[7:0] == thr[n][7:0])
				: (count_value == thr[n]);
			assign match_hi[n] = (count_value[15:8] == thr[n][15:8]);

			// lower or full channel output, changes on the tick after the compare
			always_ff @(posedge clk_sys or negedge rst_n)
			begin
				if (!rst_n)
					wave_lo_reg[n] <= 1'b0;
				else if (soft_clear || restart)
					wave_lo_reg[n] <= 1'b0;
				else if (tick && run)
				begin
					if (split_reg)
					begin
						// down count: set on match, cleared at bottom
						if (match[n])
							wave_lo_reg[n] <= 1'b1;
						else if (lo_bottom)
							wave_lo_reg[n] <= 1'b0;
					end
					else if (wave_shape_select == `SHAPE_FREQ)
					begin
						if (match[n])
							wave_lo_reg[n] <= !wave_lo_reg[n];
					end
					else if (dual)
					begin
						// match at top sets, match at bottom clears
						if (match[n])
							wave_lo_reg[n] <= going_down;
						else if (at_bottom)
							wave_lo_reg[n] <= 1'b1;
					end
					else
					begin
						// a match at bottom wins, so zero stays low
						if (match[n])
							wave_lo_reg[n] <= 1'b0;
						else if (at_bottom)
							wave_lo_reg[n] <= 1'b1;
					end
				end
			end

			// upper half output, split mode only
			always_ff @(posedge clk_sys or negedge rst_n)
			begin
				if (!rst_n)
					wave_hi_reg[n] <= 1'b0;
				else if (soft_clear || restart || !split_reg)
					wave_hi_reg[n] <= 1'b0;
				else if (tick && run)
				begin
					if (match_hi[n])
						wave_hi_reg[n] <= 1'b1;
					else if (hi_bottom)
						wave_hi_reg[n] <= 1'b0;
				end
			end

			// pin override, registered so the pin comes from a flip-flop
			always_ff @(posedge clk_sys or negedge rst_n)
			begin
				if (!rst_n)
				begin
					wave_out_pin[n] <= 1'b0;
					wave_override[n] <= 1'b0;
					wave_out_pin[n + 3] <= 1'b0;
					wave_override[n + 3] <= 1'b0;
				end
				else
				begin
					wave_override[n] <= channel_drive_enable[n]
						&& (split_reg || (wave_shape_select != `SHAPE_NORMAL));
					wave_out_pin[n] <= (channel_drive_enable[n]
						&& (split_reg || (wave_shape_select != `SHAPE_NORMAL)))
						? wave_lo_reg[n] : port_out_value[n];
					// in split mode the shape field bits enable the upper pins
					wave_override[n + 3] <= split_reg && wave_shape_select[n];
					wave_out_pin[n + 3] <= (split_reg && wave_shape_select[n])
						? wave_hi_reg[n] : port_out_value[n + 3];
				end
			end
		end
	endgenerate

	// count, stepped by direction; a software count write beats counting
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			count_value <= `RST_ZERO16;
		else if (soft_clear || restart)
			count_value <= `RST_ZERO16;
		else if (wr_fire && (idx == `REG_COUNT))
			count_value <= {strb16[1] ? pwdata[15:8] : count_value[15:8],
				strb16[0] ? pwdata[7:0] : count_value[7:0]};
		else if (tick && run)
		begin
			if (split_reg)
			begin
				// two independent halves, each reloads from its period byte
				count_value[7:0] <= lo_bottom ? cycle_active[7:0]
					: count_value[7:0] - 8'h01;
				count_value[15:8] <= hi_bottom ? cycle_active[15:8]
					: count_value[15:8] - 8'h01;
			end
			else if (dual)
			begin
				if (!dir_reg)
					count_value <= at_top ? count_value - 16'h0001
						: count_value + 16'h0001;
				else
					count_value <= at_bottom ? count_value + 16'h0001
						: count_value - 16'h0001;
			end
			else if (!dir_reg)
				count_value <= at_top ? `RST_ZERO16 : count_value + 16'h0001;
			else
				count_value <= at_bottom ? top : count_value - 16'h0001;
		end
	end

	// direction: software set/clear, turned round by dual ramp
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			dir_reg <= 1'b0;
		else if (soft_clear || restart)
			dir_reg <= 1'b0;
		else if (wr_fire && (idx == `REG_CTRL_E_SET) && pwdata[`CTRL_E_DIR])
			dir_reg <= 1'b1;
		else if (wr_fire && (idx == `REG_CTRL_E_CLR) && pwdata[`CTRL_E_DIR])
			dir_reg <= 1'b0;
		else if (split_reg)
			dir_reg <= 1'b1;
		else if (tick && run && dual)
		begin
			if (!dir_reg && at_top)
				dir_reg <= 1'b1;
			else if (dir_reg && at_bottom)
				dir_reg <= 1'b0;
		end
	end

	// hold bit, set/clear pair
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			hold_reload_bit <= 1'b0;
		else if (soft_clear)
			hold_reload_bit <= 1'b0;
		else if (wr_fire && (idx == `REG_CTRL_E_SET) && pwdata[`CTRL_E_HOLD])
			hold_reload_bit <= 1'b1;
		else if (wr_fire && (idx == `REG_CTRL_E_CLR) && pwdata[`CTRL_E_HOLD])
			hold_reload_bit <= 1'b0;
	end

	// plain control registers
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			enable_reg <= 1'b0;
			prescale_select <= 3'h0;
			wave_shape_select <= `SHAPE_NORMAL;
			channel_drive_enable <= 3'h0;
			ctrl_c_reg <= 3'h0;
			split_reg <= 1'b0;
		end
		else if (soft_clear)
		begin
			enable_reg <= 1'b0;
			prescale_select <= 3'h0;
			wave_shape_select <= `SHAPE_NORMAL;
			channel_drive_enable <= 3'h0;
			ctrl_c_reg <= 3'h0;
			split_reg <= 1'b0;
		end
		else if (wr_fire && pstrb[0])
		begin
			if (idx == `REG_CTRL_A)
			begin
				enable_reg <= pwdata[`CTRL_A_ENABLE];
				prescale_select <= pwdata[`CTRL_A_PRESC_LSB +: 3];
			end
			if (idx == `REG_CTRL_B)
			begin
				wave_shape_select <= pwdata[2:0];
				channel_drive_enable <= pwdata[`CTRL_B_EN_LSB +: 3];
			end
			if (idx == `REG_CTRL_C)
				ctrl_c_reg <= pwdata[2:0];
			if (idx == `REG_CTRL_D)
				split_reg <= pwdata[`CTRL_D_SPLIT];
		end
	end

	// flag sources; upper half compares never set a flag
	always_comb
	begin
		flag_set = 7'h00;
		if (tick && run)
		begin
			if (split_reg)
			begin
				flag_set[`FLAG_LOW_UNF] = lo_bottom;
				flag_set[`FLAG_HIGH_UNF] = hi_bottom;
			end
			else
				flag_set[`FLAG_LOW_UNF] = top_evt || bottom_evt;
			flag_set[`FLAG_CMP_LSB +: 3] = match;
		end
	end

	// sticky flags, write one to clear, a new event beats the clear
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			flags_reg <= 7'h00;
		else if (soft_clear)
			flags_reg <= 7'h00;
		else if (wr_fire && (idx == `REG_FLAGS) && pstrb[0])
			flags_reg <= (flags_reg & ~pwdata[6:0]) | flag_set;
		else
			flags_reg <= flags_reg | flag_set;
	end

	// read mux
	always_comb
	begin
		rd_data = 32'h0000_0000;
		mapped = 1'b1;
		unique case (idx)
			`REG_CTRL_A: rd_data[3:0] = {prescale_select, enable_reg};
			`REG_CTRL_B: rd_data[6:0] = {channel_drive_enable, 1'b0, wave_shape_select};
			`REG_CTRL_C: rd_data[2:0] = ctrl_c_reg;
			`REG_CTRL_D: rd_data[0] = split_reg;
			`REG_CTRL_E_CLR, `REG_CTRL_E_SET: rd_data[1:0] = {hold_reload_bit, dir_reg};
			`REG_CTRL_F_CLR, `REG_CTRL_F_SET: rd_data[3:0] = {thr_valid, cycle_valid};
			`REG_FLAGS: rd_data[6:0] = flags_reg;
			`REG_COUNT: rd_data[15:0] = count_value;
			`REG_CYCLE: rd_data[15:0] = cycle_active;
			`REG_CYCLE_SHD: rd_data[15:0] = cycle_shadow;
			6'h0c: rd_data[15:0] = thr[0];
			6'h0d: rd_data[15:0] = thr[1];
			6'h0e: rd_data[15:0] = thr[2];
			6'h0f: rd_data[15:0] = thr_shadow[0];
			6'h10: rd_data[15:0] = thr_shadow[1];
			`REG_LAST: rd_data[15:0] = thr_shadow[2];
			default: mapped = 1'b0;
		endcase
	end

	// apb answer: one wait state, ready and data registered together
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pready <= 1'b0;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end
		else
		begin
			pready <= psel && penable && !pready;
			if (psel && penable && !pready)
			begin
				prdata <= pwrite ? 32'h0000_0000 : rd_data;
				pslverr <= !mapped;
			end
			else
				pslverr <= 1'b0;
		end
	end
endmodule // wave_timer

// File: verification/wave_timer_properties.sv
`timescale 1ns/100ps
`include "wave_timer_cfg.svh"
// protocol and pin checks seen only from the timer's ports
module wave_timer_properties
	import wave_timer_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [5:0] port_out_value,
	input wire logic [5:0] wave_out_pin,
	input wire logic [5:0] wave_override
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);

	// exactly one wait state on every access
	AST_READY_ONE_WAIT: assert property (psel && penable && !pready |=> pready)
		else $error("ready missing after access cycle");
	AST_READY_IN_ACCESS: assert property (pready |-> psel && penable)
		else $error("ready outside an access");
	AST_READY_PULSE: assert property (pready |=> !pready)
		else $error("ready held longer than one cycle");
	AST_ERR_WITH_READY: assert property (pslverr |-> pready)
		else $error("error without ready");
	AST_UNMAPPED: assert property (pready && paddr[7:2] > `REG_LAST |->
		pslverr && prdata == 32'h0000_0000)
		else $error("unmapped access not refused");
	AST_MAPPED_OK: assert property (pready && paddr[7:2] <= `REG_LAST |-> !pslverr)
		else $error("mapped access refused");
	AST_WRITE_NO_DATA: assert property (pready && pwrite |-> prdata == 32'h0000_0000)
		else $error("read data on a write");
	AST_UPPER_ZERO: assert property (pready |-> prdata[31:16] == 16'h0000)
		else $error("upper read bits not zero");
	// bits left to the port on two edges in a row carry its value; avoids a handover race
	AST_PORT_PASS: assert property ($past(rst_n) |->
		((wave_out_pin ^ $past(port_out_value)) & ~(wave_override | $past(wave_override)))
		== 6'h00)
		else $error("port value not passed through");
endmodule // wave_timer_properties

// File: verification/port_pin_model.sv
`timescale 1ns/100ps
// port side: registers its own output value, pin shows the timer's muxed result
module port_pin_model
(
	input wire logic clk_sys,
	input wire logic [5:0] port_value_req,
	input wire logic [5:0] wave_out_pin,
	input wire logic [5:0] wave_override,
	output logic [5:0] port_out_value = 6'h00,
	output logic [5:0] pin_level
);
	// port output latch, as the port logic would hold it
	always @(posedge clk_sys)
		port_out_value <= port_value_req;
	// the timer already selects between wave and port value
	assign pin_level = wave_out_pin;
endmodule // port_pin_model

// File: verification/sixteen_bit_pwm_timer_waveforms_bench.sv
`timescale 1ns/100ps
`include "wave_timer_cfg.svh"
module sixteen_bit_pwm_timer_waveforms_bench;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [3:0] pstrb = 4'h0;
	logic [5:0] port_req = 6'h00;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [5:0] port_out_value;
	logic [5:0] wave_out_pin;
	logic [5:0] wave_override;
	logic [5:0] pin_level;
	logic [31:0] q;
	logic err;
	int failures = 0;
	int cmp_count = 0;
	int hi[6];
	int tog[6];

	always #5 clk_sys = ~clk_sys;

	wave_timer wave_timer_i (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .port_out_value(port_out_value),
		.wave_out_pin(wave_out_pin), .wave_override(wave_override));
	port_pin_model port_pin_model_i (.clk_sys(clk_sys), .port_value_req(port_req),
		.wave_out_pin(wave_out_pin), .wave_override(wave_override),
		.port_out_value(port_out_value), .pin_level(pin_level));

	task automatic summarize;
		$display("comparisons %0d failures %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			$display("BAD %s expected %h seen %h", nm, exp, seen);
			failures++;
		end
	endtask

	// one apb transfer; a cycle gap first keeps psel from being driven twice in one step
	task automatic apb(input logic wr, input logic [5:0] idx, input logic [15:0] d,
		input logic [3:0] s, output logic [31:0] rq, output logic re);
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {idx, 2'b00};
		pwdata <= {16'h0000, d};
		pstrb <= s;
		@(posedge clk_sys);
		penable <= 1'b1;
		// no cycle budget here, a stuck slave is left to the watchdog
		do
		begin
			@(posedge clk_sys);
		end
		while (pready !== 1'b1);
		rq = prdata;
		re = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [5:0] idx, input logic [15:0] d);
		apb(1'b1, idx, d, 4'hf, q, err);
	endtask

	task automatic rd(input logic [5:0] idx);
		apb(1'b0, idx, 16'h0000, 4'h0, q, err);
	endtask

	// stop the timer and restore every register
	task automatic restore;
		wr(`REG_CTRL_A, 16'h0000);
		wr(`REG_CTRL_E_SET, 16'h000c);
	endtask

	// counts high samples and changes per pin over a window
	task automatic watch(input int cyc);
		logic [5:0] prev;
		prev = pin_level;
		hi = '{default: 0};
		tog = '{default: 0};
		repeat (cyc)
		begin
			@(posedge clk_sys);
			foreach (hi[b])
			begin
				hi[b] += int'(pin_level[b] === 1'b1);
				tog[b] += int'(pin_level[b] !== prev[b]);
			end
			prev = pin_level;
		end
	endtask

	// hang guard, far above the few hundred cycles the sequence needs
	initial
	begin
		repeat (5000) @(posedge clk_sys);
		failures++;
		summarize();
	end

	initial
	begin
		repeat (4) @(posedge clk_sys);
		rst_n <= 1'b1;
		rd(`REG_CYCLE);
		check("cycle reset", q, 32'h0000_ffff);
		rd(6'h12);
		check("unmapped err", {31'h0, err}, 32'h0000_0001);
		// period direct write, shadow, then update under hold
		wr(`REG_CYCLE, 16'h0005);
		rd(`REG_CYCLE);
		check("cycle direct", q, 32'h0000_0005);
		wr(`REG_CYCLE_SHD, 16'h0009);
		rd(`REG_CYCLE);
		check("cycle held", q, 32'h0000_0005);
		rd(`REG_CTRL_F_SET);
		check("valid set", q & 32'h1, 32'h0000_0001);
		wr(`REG_CTRL_E_SET, 16'h0002);
		wr(`REG_CTRL_E_SET, 16'h0004);
		rd(`REG_CYCLE);
		check("update cmd", q, 32'h0000_0009);
		rd(`REG_CTRL_F_SET);
		check("valid clear", q & 32'h1, 32'h0000_0000);
		// single byte write keeps the other byte
		wr(`REG_CYCLE, 16'h1234);
		apb(1'b1, `REG_CYCLE, 16'h5656, 4'h1, q, err);
		rd(`REG_CYCLE);
		check("byte write", q, 32'h0000_1256);
		// reset command ignored while running, honoured when stopped
		wr(`REG_CTRL_A, 16'h0001);
		wr(`REG_CTRL_E_SET, 16'h000c);
		rd(`REG_CYCLE);
		check("reset ignored", q, 32'h0000_1256);
		restore();
		rd(`REG_CYCLE);
		check("reset done", q, 32'h0000_ffff);
		// stopped counter holds, restart clears count and direction
		wr(`REG_COUNT, 16'h0007);
		repeat (5) @(posedge clk_sys);
		rd(`REG_COUNT);
		check("count held", q, 32'h0000_0007);
		wr(`REG_CTRL_E_SET, 16'h0001);
		wr(`REG_CTRL_E_SET, 16'h0008);
		rd(`REG_COUNT);
		check("restart count", q, 32'h0000_0000);
		rd(`REG_CTRL_E_CLR);
		check("restart dir", q, 32'h0000_0000);
		// single ramp, top 3: half duty, static low, static high
		wr(`REG_CYCLE, 16'h0003);
		wr(`REG_THR0, 16'h0002);
		wr(`REG_THR0 + 6'h01, 16'h0000);
		wr(`REG_THR0 + 6'h02, 16'h0005);
		wr(`REG_CTRL_B, 16'h0073);
		port_req <= 6'h2a;
		wr(`REG_CTRL_A, 16'h0001);
		repeat (10) @(posedge clk_sys);
		watch(8);
		check("ramp duty", hi[0], 4);
		check("ramp edges", tog[0], 4);
		check("ramp low", hi[1], 0);
		check("ramp high", hi[2], 8);
		check("override", {26'h0, wave_override}, 32'h0000_0007);
		check("port pins", {29'h0, pin_level[5:3]}, 32'h0000_0005);
		rd(`REG_FLAGS);
		check("cmp flags", {29'h0, q[6:4]}, 32'h0000_0003);
		// threshold shadow lands at the next top, the hold bit keeps it back
		wr(`REG_SHD0, 16'h0001);
		repeat (6) @(posedge clk_sys);
		rd(`REG_THR0);
		check("thr update", q, 32'h0000_0001);
		wr(`REG_CTRL_E_SET, 16'h0002);
		wr(`REG_SHD0, 16'h0003);
		repeat (6) @(posedge clk_sys);
		rd(`REG_THR0);
		check("thr held", q, 32'h0000_0001);
		// dual ramp, top 3: period of six counts
		restore();
		wr(`REG_CYCLE, 16'h0003);
		wr(`REG_THR0 + 6'h01, 16'h0003);
		wr(`REG_THR0 + 6'h02, 16'h0002);
		wr(`REG_CTRL_B, 16'h0076);
		wr(`REG_CTRL_A, 16'h0001);
		repeat (12) @(posedge clk_sys);
		watch(12);
		check("dual low", hi[0], 0);
		check("dual high", hi[1], 12);
		check("dual duty", hi[2], 8);
		check("dual edges", tog[2], 4);
		// frequency mode, threshold zero: toggles every clock
		restore();
		wr(`REG_CTRL_B, 16'h0071);
		wr(`REG_CTRL_A, 16'h0001);
		repeat (5) @(posedge clk_sys);
		watch(6);
		check("freq toggle", tog[0], 6);
		// prescale by two: one toggle every second clock
		wr(`REG_CTRL_A, 16'h0003);
		repeat (5) @(posedge clk_sys);
		watch(6);
		check("freq presc", tog[0], 3);
		// split: both halves underflow on their own
		restore();
		wr(`REG_CTRL_D, 16'h0001);
		wr(`REG_CYCLE, 16'h0302);
		// low byte never reached by the low counter, high byte hit by the upper one
		wr(`REG_THR0, 16'h0105);
		wr(`REG_CTRL_B, 16'h0001);
		wr(`REG_CYCLE_SHD, 16'h0101);
		rd(`REG_CTRL_F_SET);
		check("split no shadow", q, 32'h0000_0000);
		wr(`REG_CTRL_A, 16'h0001);
		repeat (20) @(posedge clk_sys);
		rd(`REG_FLAGS);
		check("split unf", {30'h0, q[1:0]}, 32'h0000_0003);
		check("split no hi cmp", {31'h0, q[4]}, 32'h0000_0000);
		// upper half reloads 3, so a period of four with one high cycle
		watch(8);
		check("split upper", hi[3], 2);
		check("split override", {26'h0, wave_override}, 32'h0000_0008);
		summarize();
	end
endmodule // sixteen_bit_pwm_timer_waveforms_bench

bind wave_timer wave_timer_properties wave_timer_properties_i (.clk_sys(clk_sys),
	.rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.port_out_value(port_out_value), .wave_out_pin(wave_out_pin),
	.wave_override(wave_override));
